/* verilog/clock_modes_defines.svh */
// register offsets, field positions, reset values and divider codes
`ifndef CLOCK_MODES_DEFINES_SVH
`define CLOCK_MODES_DEFINES_SVH

// register offsets on the special function register port
`define ADDR_POWER_MODE_CONTROL   8'h87
`define ADDR_SYSTEM_CLOCK_CONTROL 8'hD8
`define ADDR_TRIM_WATCHDOG_CONFIG 8'hF7

// power_mode_control field positions
`define PMC_IDLE_BIT      0
`define PMC_STOP_BIT      1
`define PMC_GENERAL0_BIT  2
`define PMC_GENERAL1_BIT  3
`define PMC_BAUD_BIT      7

// system_clock_control field positions
`define SCC_DIV_LSB       0
`define SCC_SOURCE_BIT    2
`define SCC_FAST_STOP_BIT 3
`define SCC_PERIPH_BIT    4
`define SCC_FAST_TYPE_BIT 6
`define SCC_SLOW_TYPE_BIT 7

// clock_trim_watchdog_config field positions
`define CFG_TRIM_LSB      0
`define CFG_WDT_LSB       6

// reset values
`define PMC_RESET         8'h00
`define SCC_RESET         8'h03
`define CFG_RESET         8'h00

// prescaler codes and their ratios
`define DIV_CODE_16       2'h0
`define DIV_CODE_4        2'h1
`define DIV_CODE_2        2'h2
`define DIV_CODE_1        2'h3
`define DIV_LIMIT_16      4'hF
`define DIV_LIMIT_4       4'h3
`define DIV_LIMIT_2       4'h1
`define DIV_LIMIT_1       4'h0

// watchdog reset codes
`define WDT_FAST_SLOW     2'h2
`define WDT_ALWAYS        2'h3

`endif

/* verilog/clock_modes_pkg.sv */
// types shared by the clock and power mode block
package clock_modes_pkg;

  // operating state, gray coded along run to idle to stop
  typedef enum logic [1:0]
  {
    MODE_RUN  = 2'b00,
    MODE_IDLE = 2'b01,
    MODE_STOP = 2'b11
  } power_state_t;

  // one access from the processor on the register port
  typedef struct packed
  {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } sfr_req_t;

  // oscillator and pad controls
  typedef struct packed
  {
    logic fastRcOn;
    logic fastXtalOn;
    logic slowXtalOn;
    logic xtalPinsOn;
    logic highGain;
  } osc_ctrl_t;

  // clock enables handed to the rest of the chip
  typedef struct packed
  {
    logic cpu;
    logic periph;
    logic timer3;
    logic watchdog;
  } clock_gate_t;

endpackage : clock_modes_pkg

/* verilog/pin_sync.sv */
// three stage synchroniser with agreement filter for pin inputs
`timescale 1ns/10ps
module pin_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clock,
  input  wire logic             rst_n,
  input  wire logic             clkEn,
  input  wire logic [WIDTH-1:0] rawIn,
  output logic      [WIDTH-1:0] syncOut
);
  logic [WIDTH-1:0] stage1_reg;   // first stage, read only by stage2
  logic [WIDTH-1:0] stage2_reg;   // second stage
  logic [WIDTH-1:0] stage3_reg;   // third stage
  logic [WIDTH-1:0] agreed_reg;   // filtered level

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++)
    begin : g_bit
      // a change counts only once stage2 and stage3 agree
      always_ff @(posedge clock or negedge rst_n)
      begin
        if (!rst_n)
        begin
          stage1_reg[i] <= 1'b1;
          stage2_reg[i] <= 1'b1;
          stage3_reg[i] <= 1'b1;
          agreed_reg[i] <= 1'b1;
        end
        else if (clkEn)
        begin
          stage1_reg[i] <= rawIn[i];
          stage2_reg[i] <= stage1_reg[i];
          stage3_reg[i] <= stage2_reg[i];
          if (stage2_reg[i] == stage3_reg[i])
            agreed_reg[i] <= stage3_reg[i];
        end
      end
    end
  endgenerate

  assign syncOut = agreed_reg;
endmodule : pin_sync

/* verilog/clock_prescaler.sv */
// prescaler that changes ratio only at a whole output period
`timescale 1ns/10ps
`include "clock_modes_defines.svh"
module clock_prescaler (
  input  wire logic       clock,
  input  wire logic       rst_n,
  input  wire logic       clkEn,
  input  wire logic       srcTick,
  input  wire logic [1:0] ratioCode,
  output logic            sysTick
);
  logic [3:0] count_reg;   // source ticks seen in this period
  logic [3:0] limit_reg;   // ratio in force for this period
  logic [3:0] limitNext;   // ratio decoded from the request
  logic       wrap;        // last source tick of the period

  // code to terminal count
  assign limitNext = (ratioCode == `DIV_CODE_16) ? `DIV_LIMIT_16 :
                     (ratioCode == `DIV_CODE_4)  ? `DIV_LIMIT_4  :
                     (ratioCode == `DIV_CODE_2)  ? `DIV_LIMIT_2  : `DIV_LIMIT_1;
  assign wrap    = srcTick && (count_reg == limit_reg);
  assign sysTick = wrap;

  // a new ratio is taken only at wrap so no period is cut short
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      count_reg <= 4'h0;
      limit_reg <= `DIV_LIMIT_1;
    end
    else if (clkEn && srcTick)
    begin
      if (wrap)
      begin
        count_reg <= 4'h0;
        limit_reg <= limitNext;
      end
      else
        count_reg <= count_reg + 4'h1;
    end
  end
endmodule : clock_prescaler

/* verilog/system_clock_and_power_modes.sv */
// clock source selection, prescaler and idle/stop mode control
`timescale 1ns/10ps
`include "clock_modes_defines.svh"

// What this block does
// - fast clock is fast crystal or RC halved
// - slow clock is slow crystal or slow RC
// - reset leaves slow mode on slow RC
// - prescaler divides by 16, 4, 2, 1
// - illegal clock control writes leave bits unchanged
// - slow type writable only in fast mode
// - fast type writable only in slow mode
// - fast stop writable only in slow mode
// - source select writable only with fast running
// - idle periph stop gates most peripheral clocks
// - five bit RC trim, readable and writable
// - optional system clock halved onto a pin
// - idle halts processor, interrupt or reset wakes
// - stop halts clocks, watchdog runs if always enabled
// - only pin wake or reset leaves stop
// - stop refused while enabled wake pin low
// - trim/watchdog register loaded at power-on
// - watchdog reset control codes per mode
module system_clock_and_power_modes (
  input  wire logic                        clock,
  input  wire logic                        rst_n,
  input  wire logic                        clkEn,
  // register port from the processor
  input  wire clock_modes_pkg::sfr_req_t   sfrReq,
  output logic [7:0]                       sfrRdata,
  output logic                             sfrHit,
  // raw oscillator outputs, asynchronous to clock
  input  wire logic                        fastXtalRaw,
  input  wire logic                        fastRcRaw,
  input  wire logic                        slowXtalRaw,
  input  wire logic                        slowRcRaw,
  // external interrupt pins and their wake enables
  input  wire logic [2:0]                  extIrqPinRaw,
  input  wire logic [2:0]                  extIrqWakeEnable,
  // wake sources from the interrupt logic
  input  wire logic                        pinWakeEvent,
  input  wire logic                        enabledIrqPending,
  // power-on load of the nonvolatile configuration byte
  input  wire logic                        nvLoadStrobe,
  input  wire logic [7:0]                  nvConfigByte,
  // clock output pin configuration bit
  input  wire logic                        clockOutputConfig,
  // results
  output clock_modes_pkg::osc_ctrl_t       oscCtrl,
  output clock_modes_pkg::clock_gate_t     clockGate,
  output clock_modes_pkg::power_state_t    powerState,
  output logic [4:0]                       rcTrimValue,
  output logic                             watchdogResetEnable,
  output logic                             sysTick,
  output logic                             fastSelected,
  output logic                             clockHalfOutput,
  output logic                             clockHalfDrive_n
);
  import clock_modes_pkg::*;

  // register storage
  logic [7:0]   clkCtrl_reg;       // system_clock_control
  logic [7:0]   clkCtrlNext;       // guarded next value
  logic [7:0]   cfg_reg;           // clock_trim_watchdog_config
  logic [2:0]   pmcKeep_reg;       // general bits of power_mode_control
  power_state_t state_reg;         // run, idle or stop
  power_state_t stateNext;         // next operating state

  // synchronised pins and edge history
  logic [3:0]   oscSync;           // fast xtal, fast rc, slow xtal, slow rc
  logic [3:0]   oscPrev_reg;       // previous filtered oscillator levels
  logic [3:0]   oscRise;           // rising edge of each oscillator
  logic [2:0]   irqPinSync;        // filtered interrupt pins
  logic         rcHalf_reg;        // divide-by-two phase of fast RC

  // source selection
  logic         fastTick;          // selected fast clock edge
  logic         slowTick;          // selected slow clock edge
  logic         srcSel_reg;        // source in force, changes at period end
  logic         srcTick;           // edge of the source in force
  logic         ckoPhase_reg;      // system clock halved

  // register port decode
  logic         hitPmc;            // power_mode_control addressed
  logic         hitScc;            // system_clock_control addressed
  logic         hitCfg;            // clock_trim_watchdog_config addressed
  logic         wrPmc;             // write to power_mode_control
  logic         wrScc;             // write to system_clock_control
  logic         wrCfg;             // write to clock_trim_watchdog_config
  logic         stopBlocked;       // an enabled wake pin is low
  logic         wantIdle;          // idle requested by this write
  logic         wantStop;          // stop requested by this write
  logic [7:0]   pmcRead;           // read view of power_mode_control

  // field views of the control register
  logic         slowType;          // slow crystal when set
  logic         fastType;          // fast crystal when set
  logic         periphStop;        // idle peripheral clock stop
  logic         fastStop;          // fast oscillator stopped
  logic         sourceSel;         // fast clock requested
  logic [1:0]   dividerCode;       // prescaler code
  logic [1:0]   wdtCode;           // watchdog reset control

  // compares an address against one register offset
  function automatic logic addrIs(input logic [7:0] a, input logic [7:0] off);
    addrIs = (a == off);
  endfunction : addrIs

  // guard one bit: takes the written value only when allowed
  function automatic logic guardBit(input logic oldV, input logic newV,
                                    input logic allow);
    guardBit = allow ? newV : oldV;
  endfunction : guardBit

  // oscillator pins come from other clock domains
  pin_sync #(
    .WIDTH (4)
  ) u_osc_sync (
    .clock   (clock),
    .rst_n   (rst_n),
    .clkEn   (clkEn),
    .rawIn   ({fastXtalRaw, fastRcRaw, slowXtalRaw, slowRcRaw}),
    .syncOut (oscSync)
  );

  // interrupt pins are asynchronous as well
  pin_sync #(
    .WIDTH (3)
  ) u_irq_sync (
    .clock   (clock),
    .rst_n   (rst_n),
    .clkEn   (clkEn),
    .rawIn   (extIrqPinRaw),
    .syncOut (irqPinSync)
  );

  // field views
  assign slowType    = clkCtrl_reg[`SCC_SLOW_TYPE_BIT];
  assign fastType    = clkCtrl_reg[`SCC_FAST_TYPE_BIT];
  assign periphStop  = clkCtrl_reg[`SCC_PERIPH_BIT];
  assign fastStop    = clkCtrl_reg[`SCC_FAST_STOP_BIT];
  assign sourceSel   = clkCtrl_reg[`SCC_SOURCE_BIT];
  assign dividerCode = clkCtrl_reg[`SCC_DIV_LSB +: 2];
  assign wdtCode     = cfg_reg[`CFG_WDT_LSB +: 2];

  // edge extraction on filtered oscillator levels
  assign oscRise = oscSync & ~oscPrev_reg;

  // fast RC is halved, the crystal is used directly
  assign fastTick = fastType ? oscRise[3] : (oscRise[2] && rcHalf_reg);
  // slow crystal or slow RC
  assign slowTick = slowType ? oscRise[1] : oscRise[0];
  // nothing runs in stop
  assign srcTick  = (state_reg != MODE_STOP) &&
                    (srcSel_reg ? fastTick : slowTick);

  // prescaler after the source mux
  clock_prescaler u_prescaler (
    .clock     (clock),
    .rst_n     (rst_n),
    .clkEn     (clkEn),
    .srcTick   (srcTick),
    .ratioCode (dividerCode),
    .sysTick   (sysTick)
  );

  // edge history, RC halving phase, source in force, halved output
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      oscPrev_reg  <= 4'hF;   // matches the synchroniser reset, no false edge
      rcHalf_reg   <= 1'b0;
      srcSel_reg   <= 1'b0;   // slow clock after reset
      ckoPhase_reg <= 1'b0;
    end
    else if (clkEn)
    begin
      oscPrev_reg <= oscSync;
      if (oscRise[2])
        rcHalf_reg <= ~rcHalf_reg;
      // switch at a period end, or at once while in stop
      if (sysTick || (state_reg == MODE_STOP))
        srcSel_reg <= sourceSel;
      // toggles per tick: clock over two
      if (sysTick)
        ckoPhase_reg <= ~ckoPhase_reg;
    end
  end

  // register port decode
  assign hitPmc = addrIs(sfrReq.addr, `ADDR_POWER_MODE_CONTROL);
  assign hitScc = addrIs(sfrReq.addr, `ADDR_SYSTEM_CLOCK_CONTROL);
  assign hitCfg = addrIs(sfrReq.addr, `ADDR_TRIM_WATCHDOG_CONFIG);
  assign sfrHit = (sfrReq.wr || sfrReq.rd) && (hitPmc || hitScc || hitCfg);
  assign wrPmc  = sfrReq.wr && hitPmc;
  assign wrScc  = sfrReq.wr && hitScc;
  assign wrCfg  = sfrReq.wr && hitCfg;

  // guarded bits keep old value on forbidden change
  always_comb
  begin
    clkCtrlNext = clkCtrl_reg;
    if (wrScc)
    begin
      // slow type only in fast mode
      clkCtrlNext[`SCC_SLOW_TYPE_BIT] = guardBit(slowType,
        sfrReq.wdata[`SCC_SLOW_TYPE_BIT], sourceSel);
      // fast type only in slow mode
      clkCtrlNext[`SCC_FAST_TYPE_BIT] = guardBit(fastType,
        sfrReq.wdata[`SCC_FAST_TYPE_BIT], !sourceSel);
      // fast stop only in slow mode
      clkCtrlNext[`SCC_FAST_STOP_BIT] = guardBit(fastStop,
        sfrReq.wdata[`SCC_FAST_STOP_BIT], !sourceSel);
      // source select only while the fast oscillator runs
      clkCtrlNext[`SCC_SOURCE_BIT] = guardBit(sourceSel,
        sfrReq.wdata[`SCC_SOURCE_BIT], !fastStop);
      clkCtrlNext[`SCC_PERIPH_BIT] = sfrReq.wdata[`SCC_PERIPH_BIT];
      clkCtrlNext[`SCC_DIV_LSB +: 2] = sfrReq.wdata[`SCC_DIV_LSB +: 2];
      // bit 5 stays reserved and reads zero
      clkCtrlNext[5] = 1'b0;
    end
  end

  // control register; guards judge old values
  // so one write from both clear can set both stop and source
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      clkCtrl_reg <= `SCC_RESET;   // slow RC, divide by 1
    else if (clkEn)
      clkCtrl_reg <= clkCtrlNext;
  end

  // trim/watchdog; power-on load wins
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      cfg_reg <= `CFG_RESET;
    else if (clkEn)
    begin
      if (nvLoadStrobe)
        cfg_reg <= nvConfigByte & 8'hDF;
      else if (wrCfg)
        cfg_reg <= sfrReq.wdata & 8'hDF;   // trim is run-time writable
    end
  end

  // general bits of the power register are plain storage
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      pmcKeep_reg <= 3'h0;
    else if (clkEn && wrPmc)
      pmcKeep_reg <= {sfrReq.wdata[`PMC_BAUD_BIT],
                      sfrReq.wdata[`PMC_GENERAL1_BIT],
                      sfrReq.wdata[`PMC_GENERAL0_BIT]};
  end

  // a low pin with wake enabled vetoes stop
  assign stopBlocked = |(~irqPinSync & extIrqWakeEnable);
  assign wantIdle    = wrPmc && sfrReq.wdata[`PMC_IDLE_BIT];
  assign wantStop    = wrPmc && sfrReq.wdata[`PMC_STOP_BIT];

  // operating state transitions
  always_comb
  begin
    case (state_reg)
      MODE_RUN:
      begin
        if (wantStop && !stopBlocked)
          stateNext = MODE_STOP;
        else if (wantIdle)
          stateNext = MODE_IDLE;
        else
          stateNext = MODE_RUN;
      end
      MODE_IDLE:
      begin
        // any enabled interrupt ends idle
        stateNext = enabledIrqPending ? MODE_RUN : MODE_IDLE;
      end
      MODE_STOP:
      begin
        // only a pin wake ends stop; other interrupts are ignored
        stateNext = pinWakeEvent ? MODE_RUN : MODE_STOP;
      end
      default:
        stateNext = MODE_RUN;
    endcase
  end

  // state register; reset is the other way out of idle and stop
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      state_reg <= MODE_RUN;
    else if (clkEn)
      state_reg <= stateNext;
  end

  // request bits read back the mode
  assign pmcRead = {pmcKeep_reg[2], 3'h0, pmcKeep_reg[1], pmcKeep_reg[0],
                    state_reg == MODE_STOP, state_reg == MODE_IDLE};

  // read data is registered; unmapped addresses read zero
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      sfrRdata <= 8'h00;
    else if (clkEn && sfrReq.rd)
    begin
      if (hitPmc)
        sfrRdata <= pmcRead;
      else if (hitScc)
        sfrRdata <= clkCtrl_reg;
      else if (hitCfg)
        sfrRdata <= cfg_reg;
      else
        sfrRdata <= 8'h00;
    end
  end

  // oscillator controls; a stopped fast clock saves power
  assign oscCtrl.fastRcOn   = !fastStop && !fastType &&
                              (state_reg != MODE_STOP);
  assign oscCtrl.fastXtalOn = !fastStop && fastType &&
                              (state_reg != MODE_STOP);
  assign oscCtrl.slowXtalOn = slowType && (state_reg != MODE_STOP);
  // crystal pins serve either crystal type
  assign oscCtrl.xtalPinsOn = slowType || fastType;
  // high gain for the fast crystal
  assign oscCtrl.highGain   = fastType;

  // clock gating per mode
  assign clockGate.cpu      = (state_reg == MODE_RUN);
  // peripherals run in idle unless the stop bit is set
  assign clockGate.periph   = (state_reg == MODE_RUN) ||
                              ((state_reg == MODE_IDLE) && !periphStop);
  // timer3 and pin logic stay alive in idle
  assign clockGate.timer3   = (state_reg != MODE_STOP);
  // watchdog counts in stop only when always enabled
  assign clockGate.watchdog = (state_reg == MODE_RUN) ||
                              (wdtCode == `WDT_ALWAYS);

  // watchdog reset enable by code and mode
  assign watchdogResetEnable = (wdtCode == `WDT_ALWAYS) ||
                               ((wdtCode == `WDT_FAST_SLOW) &&
                                (state_reg == MODE_RUN));

  // remaining outputs
  assign powerState       = state_reg;
  assign rcTrimValue      = cfg_reg[`CFG_TRIM_LSB +: 5];
  assign fastSelected     = srcSel_reg;
  assign clockHalfOutput  = ckoPhase_reg;
  assign clockHalfDrive_n = !clockOutputConfig;
endmodule : system_clock_and_power_modes

/* bench/osc_model.sv */
// behavioural crystals and RC oscillators feeding the clock block
`timescale 1ns/10ps
module osc_model #(
  parameter real FAST_XTAL_HALF = 83.0,
  parameter real FAST_RC_HALF   = 67.8,
  parameter real SLOW_XTAL_HALF = 15625.0,
  parameter real SLOW_RC_HALF   = 6250.0
) (
  input  wire clock_modes_pkg::osc_ctrl_t oscCtrl,
  output logic                            fastXtalRaw,
  output logic                            fastRcRaw,
  output logic                            slowXtalRaw,
  output logic                            slowRcRaw
);
  import clock_modes_pkg::*;
  // free running phases, one per source
  logic fxPhase = 1'b0;
  logic frPhase = 1'b0;
  logic sxPhase = 1'b0;
  logic srPhase = 1'b0;
  always #(FAST_XTAL_HALF) fxPhase = ~fxPhase;
  always #(FAST_RC_HALF) frPhase = ~frPhase;
  always #(SLOW_XTAL_HALF) sxPhase = ~sxPhase;
  always #(SLOW_RC_HALF) srPhase = ~srPhase;
  // a stopped source stays low
  assign fastXtalRaw = fxPhase & oscCtrl.fastXtalOn;
  assign fastRcRaw   = frPhase & oscCtrl.fastRcOn;
  assign slowXtalRaw = sxPhase & oscCtrl.slowXtalOn;
  // slow rc feeds the watchdog
  assign slowRcRaw   = srPhase;
endmodule : osc_model

/* bench/clock_modes_asserts.sv */
// concurrent checks on the ports of the clock and power mode block
`timescale 1ns/10ps
module clock_modes_asserts (
  input wire logic                          clock,
  input wire logic                          rst_n,
  input wire logic                          clkEn,
  input wire clock_modes_pkg::sfr_req_t     sfrReq,
  input wire logic [2:0]                    extIrqPinRaw,
  input wire logic [2:0]                    extIrqWakeEnable,
  input wire logic                          pinWakeEvent,
  input wire logic                          enabledIrqPending,
  input wire logic                          clockOutputConfig,
  input wire clock_modes_pkg::clock_gate_t  clockGate,
  input wire clock_modes_pkg::power_state_t powerState,
  input wire logic                          sysTick,
  input wire logic                          fastSelected,
  input wire logic                          clockHalfOutput,
  input wire logic                          clockHalfDrive_n
);
  import clock_modes_pkg::*;
  // cycles a wake pin has been held low
  logic [2:0] pinHold_reg;
  logic [2:0] pinHold_next;
  wire        pinBlock = |(~extIrqPinRaw & extIrqWakeEnable);
  assign pinHold_next = !pinBlock ? 3'h0 : (&pinHold_reg ? pinHold_reg : pinHold_reg + 3'h1);
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      pinHold_reg <= 3'h0;
    else
      pinHold_reg <= pinHold_next;
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  // power mode writes from run
  sequence pmcWrite;
    clkEn && sfrReq.wr && sfrReq.addr == 8'h87 && powerState == MODE_RUN;
  endsequence
  sequence idleReq;
    pmcWrite ##0 sfrReq.wdata[1:0] == 2'h1;
  endsequence
  sequence stopReq;
    pmcWrite ##0 sfrReq.wdata[1];
  endsequence
  reset_slow_a: assert property ($rose(rst_n) |-> powerState == MODE_RUN && !fastSelected)
    else $error("reset state wrong");
  idle_entry_a: assert property (idleReq |=> powerState == MODE_IDLE && !clockGate.cpu)
    else $error("no idle");
  idle_wake_a: assert property (powerState == MODE_IDLE && enabledIrqPending && clkEn
    |=> powerState == MODE_RUN) else $error("idle not left");
  stop_entry_a: assert property (stopReq ##0 extIrqWakeEnable == 3'h0
    |=> powerState == MODE_STOP) else $error("no stop");
  stop_refuse_a: assert property (stopReq ##0 pinHold_reg > 3'h5 |=> powerState == MODE_RUN)
    else $error("stop not refused");
  stop_hold_a: assert property (powerState == MODE_STOP && !pinWakeEvent
    |=> powerState == MODE_STOP) else $error("stop left");
  stop_wake_a: assert property (powerState == MODE_STOP && pinWakeEvent && clkEn
    |=> powerState == MODE_RUN) else $error("stop not left");
  halt_gate_a: assert property (powerState == MODE_STOP
    |-> !clockGate.cpu && !clockGate.periph && !clockGate.timer3) else $error("clock in stop");
  half_toggle_a: assert property (clkEn && sysTick |=> clockHalfOutput != $past(clockHalfOutput))
    else $error("missed toggle");
  half_hold_a: assert property (clkEn && !sysTick |=> $stable(clockHalfOutput))
    else $error("stray toggle");
  pin_drive_a: assert property (clockHalfDrive_n == !clockOutputConfig)
    else $error("drive enable wrong");
endmodule : clock_modes_asserts

bind system_clock_and_power_modes clock_modes_asserts i_chk (.*);

/* bench/testbench.sv */
// self-checking bench for the clock and power mode block
`timescale 1ns/10ps
module testbench;
  import clock_modes_pkg::*;
  typedef logic [23:0] row_t;  // address, write data, expected read back
  logic clock, rst_n, clkEn, pinWakeEvent, enabledIrqPending, nvLoadStrobe, clockOutputConfig;
  logic fastXtalRaw, fastRcRaw, slowXtalRaw, slowRcRaw, watchdogResetEnable, sysTick;
  logic fastSelected, clockHalfOutput, clockHalfDrive_n, sfrHit;
  logic [2:0] extIrqPinRaw, extIrqWakeEnable;
  logic [7:0] nvConfigByte, sfrRdata, rd;
  logic [4:0] rcTrimValue;
  sfr_req_t     sfrReq;
  osc_ctrl_t    oscCtrl;
  clock_gate_t  clockGate;
  power_state_t powerState;
  int           n_errors, n_checks;
  logic [15:0]  divs [4] = '{16'h10, 16'h4, 16'h2, 16'h1};
  // guard rows depend on their order
  row_t rows [15] = '{24'hD84343, 24'hD8C343, 24'hD84B4B, 24'hD84743,
    24'hD80303, 24'hD80707, 24'hD80F07, 24'hD84707, 24'hD88787,
    24'hD8A383, 24'hD80383, 24'hF7FFDF, 24'hF71010, 24'h878C8C, 24'h55AA00};
  system_clock_and_power_modes i_dut (.*);
  // oscillator edges land on multiples of 20 ns, the clock edges never do
  osc_model #(.FAST_XTAL_HALF(140.0), .FAST_RC_HALF(120.0), .SLOW_XTAL_HALF(300.0),
    .SLOW_RC_HALF(400.0)) i_osc (.*);
  initial
  begin
    clock = 1'b0;
    #7;
    forever #20 clock = ~clock;
  end
  task automatic print_verdict;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : print_verdict
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      n_errors++;
    end
  endtask : chk
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    sfrReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clock);
    sfrReq.wr <= 1'b0;
    #1;
  endtask : wr_reg
  // registered read data
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock);
    sfrReq <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clock);
    sfrReq.rd <= 1'b0;
    @(posedge clock);
    #1;
    d = sfrRdata;
  endtask : rd_reg
  // four ticks settle first
  task automatic measure(input logic [15:0] exp);
    logic [15:0] cnt;
    int ticks;
    cnt = 16'h0;
    ticks = 0;
    for (int i = 0; i < 8000 && ticks < 5; i++)
    begin
      @(posedge clock);
      #1;
      cnt = cnt + 16'h1;
      if (sysTick === 1'b1)
      begin
        ticks++;
        if (ticks == 5)
          chk(cnt, exp);
        cnt = 16'h0;
      end
    end
    if (ticks < 5)
    begin
      n_errors++;
      print_verdict();
    end
  endtask : measure
  // one-cycle interrupt ends idle
  task automatic wake_idle;
    @(posedge clock);
    enabledIrqPending <= 1'b1;
    @(posedge clock);
    enabledIrqPending <= 1'b0;
    @(posedge clock);
    #1;
    chk(powerState, MODE_RUN);
  endtask : wake_idle
  task automatic settle;
    @(posedge clock);
    #1;
  endtask : settle
  initial
  begin
    rst_n = 1'b0;
    sfrReq = '0;
    extIrqPinRaw = 3'h7;
    extIrqWakeEnable = 3'h0;
    clkEn = 1'b1;
    {pinWakeEvent, enabledIrqPending, nvLoadStrobe, clockOutputConfig} = 4'h0;
    nvConfigByte = 8'h00;
    n_errors = 0;
    n_checks = 0;
    repeat (5) @(posedge clock);
    rst_n <= 1'b1;
    rd_reg(8'hD8, rd);
    chk(rd, 8'h03);
    chk(fastSelected, 1'b0);
    chk(clockHalfDrive_n, 1'b1);
    foreach (rows[i])
    begin
      wr_reg(rows[i][23:16], rows[i][15:8]);
      rd_reg(rows[i][23:16], rd);
      chk(rd, rows[i][7:0]);
    end
    // slow crystal, every code
    for (int c = 0; c < 4; c++)
    begin
      wr_reg(8'hD8, {6'h20, 2'(c)});
      measure(divs[c] * 16'hF);
    end
    wr_reg(8'hD8, 8'h87);
    measure(16'hC);
    chk(fastSelected, 1'b1);
    wr_reg(8'hD8, 8'h07);
    wr_reg(8'hD8, 8'h03);
    measure(16'h14);
    wr_reg(8'hD8, 8'h43);
    wr_reg(8'hD8, 8'h47);
    measure(16'h7);
    chk({oscCtrl.xtalPinsOn, oscCtrl.highGain}, 2'h3);
    wr_reg(8'hD8, 8'h43);
    wr_reg(8'hD8, 8'h53);
    wr_reg(8'h87, 8'h01);
    settle();
    chk(clockGate, 4'h2);
    wake_idle();
    // low wake pin blocks stop
    extIrqWakeEnable <= 3'h4;
    extIrqPinRaw <= 3'h3;
    repeat (8) @(posedge clock);
    wr_reg(8'h87, 8'h02);
    settle();
    chk(powerState, MODE_RUN);
    extIrqWakeEnable <= 3'h0;
    wr_reg(8'h87, 8'h02);
    enabledIrqPending <= 1'b1;
    repeat (4) settle();
    chk(powerState, MODE_STOP);
    enabledIrqPending <= 1'b0;
    pinWakeEvent <= 1'b1;
    settle();
    pinWakeEvent <= 1'b0;
    settle();
    chk(powerState, MODE_RUN);
    for (int w = 0; w < 4; w++)
    begin
      wr_reg(8'hF7, {2'(w), 6'h10});
      chk(watchdogResetEnable, w > 1);
      wr_reg(8'h87, 8'h01);
      settle();
      chk({watchdogResetEnable, clockGate.watchdog}, {2{w == 3}});
      wake_idle();
    end
    nvConfigByte <= 8'h9A;
    nvLoadStrobe <= 1'b1;
    settle();
    nvLoadStrobe <= 1'b0;
    rd_reg(8'hF7, rd);
    chk(rd, 8'h9A);
    chk(rcTrimValue, 5'h1A);
    clockOutputConfig <= 1'b1;
    settle();
    chk(clockHalfDrive_n, 1'b0);
    // reset from fast crystal, after a clock enable freeze
    wr_reg(8'hD8, 8'h57);
    measure(16'h7);
    clkEn <= 1'b0;
    rd = {7'h0, clockHalfOutput};
    repeat (20) settle();
    chk(clockHalfOutput, rd[0]);
    clkEn <= 1'b1;
    rst_n <= 1'b0;
    repeat (2) settle();
    rst_n <= 1'b1;
    rd_reg(8'hD8, rd);
    chk(rd, 8'h03);
    chk({fastSelected, powerState}, 3'h0);
    print_verdict();
  end
endmodule : testbench
